// ==== rtl/cpu_instruction_set_decoder.v ====
// Functional notes
// - run standard opcode set, less the unsupported moves noted below
// - direct byte: low RAM or SFR
// - indirect pointer from bank R0/R1
// - immediates from bytes two and three
// - bit address: RAM flags or SFR bits
// - external moves hit on-chip data RAM
// - long call/jump load 16-bit target
// - absolute call/jump replace low 11 bits
// - relative target from next instruction
// - add/add_with_carry/subtract_with_borrow all source modes
// - logic immediate to direct, read-modify-write
// - rotates, through-carry variants use carry
// - swap accumulator nibbles
// - data pointer immediate load
// - code read at accumulator plus base
// - data pointer external moves both ways
// - 8-bit external moves, nibble exchange unsupported
// - push and pop direct bytes
// - carry and/or with bit or complement
// - jump if bit set, then clear
// - compare and jump when unequal
// - decrement and jump when nonzero
// - indirect jump to accumulator plus pointer
`timescale 1ns/1ps
`include "cpu_core_defs.vh"
module cpu_instruction_set_decoder (
	input wire clk_sys,
	input wire rst,
	output reg [15:0] code_addr_q,
	input wire [7:0] code_rdata,
	output wire [15:0] extended_internal_data_ram_addr,
	output wire [7:0] extended_internal_data_ram_wdata,
	input wire [7:0] extended_internal_data_ram_rdata,
	output wire extended_internal_data_ram_we,
	output wire [7:0] sfr_raddr,
	input wire [7:0] sfr_rdata,
	output reg sfr_we_q,
	output reg [7:0] sfr_waddr_q,
	output reg [7:0] sfr_wdata_q
);

localparam S_FETCH = 3'd0;
localparam S_B1 = 3'd1;
localparam S_B2 = 3'd2;
localparam S_EXEC = 3'd3;
localparam S_CALL = 3'd4;
localparam S_CODE_READ_MOVE = 3'd5;

reg [2:0] state_q;
reg [7:0] op_q;
reg [7:0] b1_q;
reg [7:0] b2_q;
reg [7:0] a_q;
reg [7:0] b_q;
reg [7:0] psw_q;
reg [7:0] sp_q;
reg [15:0] pc_q;
reg [15:0] dp_q;
reg [7:0] ram [0:255];

// ==========
// decode helpers
function [1:0] ilen(input [7:0] o);
	begin
		case (o)
		8'h02, 8'h10, 8'h12, 8'h20, 8'h30, 8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90, 8'hD5: ilen = 2'd3;
		8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h40, 8'h42, 8'h44, 8'h45, 8'h50, 8'h52, 8'h54, 8'h55,
		8'h60, 8'h62, 8'h64, 8'h65, 8'h70, 8'h72, 8'h74, 8'h80, 8'h82, 8'h92, 8'h94, 8'h95, 8'hA0, 8'hA2,
		8'hB0, 8'hB2, 8'hC0, 8'hC2, 8'hC5, 8'hD0, 8'hD2, 8'hE5, 8'hF5: ilen = 2'd2;
		default:
			if (o[7:4] == 4'hB && o[3:2] != 2'b00)
				ilen = 2'd3;
			else if (o[3:0] == 4'h1 || (o[7:4] == 4'hD && o[3]) ||
				(o[3:1] >= 3'd3 && (o[7:4] == 4'h7 || o[7:4] == 4'h8 || o[7:4] == 4'hA)))
				ilen = 2'd2;
			else
				ilen = 2'd1;
		endcase
	end
endfunction

function [7:0] lop(input [1:0] s, input [7:0] x, input [7:0] y);
	begin
		case (s)
		2'b00: lop = x | y;
		2'b01: lop = x & y;
		default: lop = x ^ y;
		endcase
	end
endfunction

function [7:0] setb(input [7:0] x, input [2:0] i, input v);
	begin
		setb = x;
		setb[i] = v;
	end
endfunction

// ==========
// operand fetch
wire [3:0] nib = op_q[3:0];
wire [7:0] rn_a = {3'b000, psw_q[4:3], op_q[2:0]};
wire [7:0] ri_a = {3'b000, psw_q[4:3], 2'b00, op_q[0]};
wire [7:0] ind_a = ram[ri_a];
wire bitop = (nib == 4'h0 && ((op_q[7:4] >= 4'h1 && op_q[7:4] <= 4'h3) || op_q[7:5] == 3'b101)) ||
	(nib == 4'h2 && op_q[7:4] >= 4'h7 && op_q[7:4] <= 4'hD);
wire [7:0] bb = b1_q[7] ? {b1_q[7:3], 3'b000} : {`BIT_RAM_BASE, b1_q[6:3]};
wire [7:0] ra = bitop ? bb : b1_q;
reg [7:0] dv;
reg [7:0] src;
wire bv = dv[b1_q[2:0]];
wire [7:0] dwa = (nib == 4'h5) ? b1_q : (op_q[3] ? rn_a : ind_a);
wire dws = (nib == 4'h5) && b1_q[7];
wire [7:0] rel = (ilen(op_q) == 2'd3) ? b2_q : b1_q;
wire [15:0] rt = pc_q + {{8{rel[7]}}, rel};
wire gen = (nib >= 4'h5) || (nib == 4'h4 && (op_q[7:4] == 4'h2 || op_q[7:4] == 4'h3 || op_q[7:4] == 4'h4 ||
	op_q[7:4] == 4'h5 || op_q[7:4] == 4'h6 || op_q[7:4] == 4'h7 || op_q[7:4] == 4'h9 || op_q[7:4] == 4'hB));

assign sfr_raddr = ra;
assign extended_internal_data_ram_addr = dp_q;
assign extended_internal_data_ram_wdata = a_q;
assign extended_internal_data_ram_we = (state_q == S_EXEC) && (op_q == 8'hF0);

always @*
begin
	case (ra)
	`SFR_ACC: dv = a_q;
	`SFR_B: dv = b_q;
	`SFR_PSW: dv = {psw_q[7:1], ^a_q};
	`SFR_SP: dv = sp_q;
	`SFR_DPL: dv = dp_q[7:0];
	`SFR_DPH: dv = dp_q[15:8];
	default: dv = sfr_rdata;
	endcase
	if (!ra[7])
		dv = ram[ra];
	case (nib)
	4'h4: src = b1_q;
	4'h5: src = dv;
	4'h6, 4'h7: src = ram[ind_a];
	default: src = ram[rn_a];
	endcase
end

// ==========
// arithmetic
wire sub = (op_q[7:4] == 4'h9);
wire [7:0] s2 = sub ? ~src : src;
wire ci = sub ? ~psw_q[`PSW_CY] : (op_q[4] & psw_q[`PSW_CY]);
wire [4:0] lo = {1'b0, a_q[3:0]} + {1'b0, s2[3:0]} + {4'h0, ci};
wire [7:0] mid = {1'b0, a_q[6:0]} + {1'b0, s2[6:0]} + {7'h00, ci};
wire [8:0] sum = {1'b0, a_q} + {1'b0, s2} + {8'h00, ci};
wire [15:0] prod = a_q * b_q;
wire [8:0] da1 = {1'b0, a_q} + ((a_q[3:0] > 4'h9 || psw_q[`PSW_AC]) ? 9'h006 : 9'h000);
wire [8:0] da2 = da1 + ((da1[7:4] > 4'h9 || psw_q[`PSW_CY] || da1[8]) ? 9'h060 : 9'h000);
wire [7:0] cl = (nib < 4'h6) ? a_q : src;
wire [7:0] cr = (nib == 4'h5) ? dv : b1_q;

// ==========
// execute
reg [7:0] a_d;
reg [7:0] b_d;
reg [7:0] psw_d;
reg [7:0] sp_d;
reg [15:0] pc_d;
reg [15:0] dp_d;
reg [15:0] cad_d;
reg [2:0] nst;
reg we;
reg wsfr;
reg [7:0] wa;
reg [7:0] wd;

task wr(input [7:0] ad, input s, input [7:0] v);
	begin
		we = 1'b1;
		wa = ad;
		wsfr = s;
		wd = v;
	end
endtask

task wbit(input v);
	begin
		wr(bb, b1_q[7], setb(dv, b1_q[2:0], v));
	end
endtask

always @*
begin
	a_d = a_q;
	b_d = b_q;
	psw_d = psw_q;
	sp_d = sp_q;
	pc_d = pc_q;
	dp_d = dp_q;
	nst = S_FETCH;
	we = 1'b0;
	wsfr = 1'b0;
	wa = 8'h00;
	wd = 8'h00;
	cad_d = pc_q;
	if (state_q == S_CALL)
	begin
		sp_d = sp_q + 8'h01;
		wr(sp_q + 8'h01, 1'b0, pc_q[15:8]);
		pc_d = (nib == 4'h1) ? {pc_q[15:11], op_q[7:5], b1_q} : {b1_q, b2_q};
	end
	else if (state_q == S_EXEC)
	begin
		if (nib == 4'h1 || op_q == 8'h12)
		begin
			if (op_q[4])
			begin
				sp_d = sp_q + 8'h01;
				wr(sp_q + 8'h01, 1'b0, pc_q[7:0]);
				nst = S_CALL;
			end
			else
				pc_d = {pc_q[15:11], op_q[7:5], b1_q};
		end
		else if (gen)
			case (op_q[7:4])
			4'h0: wr(dwa, dws, src + 8'h01);
			4'h1: wr(dwa, dws, src - 8'h01);
			4'h2, 4'h3, 4'h9:
			begin
				a_d = sum[7:0];
				psw_d[`PSW_CY] = sum[8] ^ sub;
				psw_d[`PSW_AC] = lo[4] ^ sub;
				psw_d[`PSW_OV] = sum[8] ^ mid[7];
			end
			4'h4, 4'h5, 4'h6: a_d = lop(op_q[5:4], a_q, src);
			4'h7:
				if (nib == 4'h4)
					a_d = b1_q;
				else
					wr(dwa, dws, (nib == 4'h5) ? b2_q : b1_q);
			4'h8:
				if (nib == 4'h5)
					wr(b2_q, b2_q[7], dv);
				else
					wr(b1_q, b1_q[7], src);
			4'hA:
				if (nib != 4'h5)
					wr(dwa, 1'b0, dv);
			4'hB:
			begin
				psw_d[`PSW_CY] = cl < cr;
				if (cl != cr)
					pc_d = rt;
			end
			4'hC:
			begin
				a_d = src;
				wr(dwa, dws, a_q);
			end
			4'hD:
				if (nib == 4'h5 || op_q[3])
				begin
					wr(dwa, dws, src - 8'h01);
					if (src != 8'h01)
						pc_d = rt;
				end
			4'hE: a_d = src;
			default: wr(dwa, dws, a_q);
			endcase
		else
			case (op_q)
			8'h02: pc_d = {b1_q, b2_q};
			8'h03: a_d = {a_q[0], a_q[7:1]};
			8'h13:
			begin
				a_d = {psw_q[`PSW_CY], a_q[7:1]};
				psw_d[`PSW_CY] = a_q[0];
			end
			8'h23: a_d = {a_q[6:0], a_q[7]};
			8'h33:
			begin
				a_d = {a_q[6:0], psw_q[`PSW_CY]};
				psw_d[`PSW_CY] = a_q[7];
			end
			8'h04: a_d = a_q + 8'h01;
			8'h14: a_d = a_q - 8'h01;
			8'h10:
				if (bv)
				begin
					wbit(1'b0);
					pc_d = rt;
				end
			8'h20: pc_d = bv ? rt : pc_q;
			8'h30: pc_d = bv ? pc_q : rt;
			8'h40: pc_d = psw_q[`PSW_CY] ? rt : pc_q;
			8'h50: pc_d = psw_q[`PSW_CY] ? pc_q : rt;
			8'h60: pc_d = (a_q == 8'h00) ? rt : pc_q;
			8'h70: pc_d = (a_q != 8'h00) ? rt : pc_q;
			8'h80: pc_d = rt;
			8'h22, 8'h32:
			begin
				pc_d = {ram[sp_q], ram[sp_q - 8'h01]};
				sp_d = sp_q - 8'h02;
			end
			8'h42, 8'h52, 8'h62: wr(b1_q, b1_q[7], lop(op_q[5:4], dv, a_q));
			8'h43, 8'h53, 8'h63: wr(b1_q, b1_q[7], lop(op_q[5:4], dv, b2_q));
			8'h72: psw_d[`PSW_CY] = psw_q[`PSW_CY] | bv;
			8'hA0: psw_d[`PSW_CY] = psw_q[`PSW_CY] | ~bv;
			8'h82: psw_d[`PSW_CY] = psw_q[`PSW_CY] & bv;
			8'hB0: psw_d[`PSW_CY] = psw_q[`PSW_CY] & ~bv;
			8'hA2: psw_d[`PSW_CY] = bv;
			8'hB3: psw_d[`PSW_CY] = ~psw_q[`PSW_CY];
			8'hC3: psw_d[`PSW_CY] = 1'b0;
			8'hD3: psw_d[`PSW_CY] = 1'b1;
			8'h92: wbit(psw_q[`PSW_CY]);
			8'hB2: wbit(~bv);
			8'hC2: wbit(1'b0);
			8'hD2: wbit(1'b1);
			8'h73: pc_d = {8'h00, a_q} + dp_q;
			8'h83, 8'h93:
			begin
				nst = S_CODE_READ_MOVE;
				cad_d = {8'h00, a_q} + (op_q[4] ? dp_q : pc_q);
			end
			8'h84:
			begin
				psw_d[`PSW_CY] = 1'b0;
				psw_d[`PSW_OV] = (b_q == 8'h00);
				if (b_q != 8'h00)
				begin
					a_d = a_q / b_q;
					b_d = a_q % b_q;
				end
			end
			8'hA4:
			begin
				a_d = prod[7:0];
				b_d = prod[15:8];
				psw_d[`PSW_CY] = 1'b0;
				psw_d[`PSW_OV] = (prod[15:8] != 8'h00);
			end
			8'h90: dp_d = {b1_q, b2_q};
			8'hA3: dp_d = dp_q + 16'h0001;
			8'hC0:
			begin
				sp_d = sp_q + 8'h01;
				wr(sp_q + 8'h01, 1'b0, dv);
			end
			8'hD0:
			begin
				sp_d = sp_q - 8'h01;
				wr(b1_q, b1_q[7], ram[sp_q]);
			end
			8'hC4: a_d = {a_q[3:0], a_q[7:4]};
			8'hD4:
			begin
				a_d = da2[7:0];
				psw_d[`PSW_CY] = psw_q[`PSW_CY] | da2[8];
			end
			8'hE0: a_d = extended_internal_data_ram_rdata;
			8'hE4: a_d = 8'h00;
			8'hF4: a_d = ~a_q;
			default: a_d = a_q;
			endcase
	end
	if (nst != S_CODE_READ_MOVE)
		cad_d = pc_d;
end

// ==========
// sequencer; pc steps past every byte before execute
always @(posedge clk_sys)
begin
	if (rst)
	begin
		state_q <= S_FETCH;
		pc_q <= `PC_RST;
		code_addr_q <= `PC_RST;
		op_q <= 8'h00;
		b1_q <= 8'h00;
		b2_q <= 8'h00;
		a_q <= 8'h00;
		b_q <= 8'h00;
		psw_q <= 8'h00;
		sp_q <= `SP_RST;
		dp_q <= 16'h0000;
		sfr_we_q <= 1'b0;
		sfr_waddr_q <= 8'h00;
		sfr_wdata_q <= 8'h00;
	end
	else
	begin
		sfr_we_q <= 1'b0;
		case (state_q)
		S_FETCH:
		begin
			op_q <= code_rdata;
			pc_q <= pc_q + 16'h0001;
			code_addr_q <= pc_q + 16'h0001;
			state_q <= (ilen(code_rdata) == 2'd1) ? S_EXEC : S_B1;
		end
		S_B1, S_B2:
		begin
			if (state_q == S_B1)
				b1_q <= code_rdata;
			else
				b2_q <= code_rdata;
			pc_q <= pc_q + 16'h0001;
			code_addr_q <= pc_q + 16'h0001;
			state_q <= (state_q == S_B1 && ilen(op_q) == 2'd3) ? S_B2 : S_EXEC;
		end
		S_EXEC, S_CALL:
		begin
			a_q <= a_d;
			b_q <= b_d;
			psw_q <= {psw_d[7:1], 1'b0};
			sp_q <= sp_d;
			dp_q <= dp_d;
			pc_q <= pc_d;
			code_addr_q <= cad_d;
			state_q <= nst;
			// explicit sfr writes win over implied updates
			if (we && wsfr)
				case (wa)
				`SFR_ACC: a_q <= wd;
				`SFR_B: b_q <= wd;
				`SFR_PSW: psw_q <= {wd[7:1], 1'b0};
				`SFR_SP: sp_q <= wd;
				`SFR_DPL: dp_q[7:0] <= wd;
				`SFR_DPH: dp_q[15:8] <= wd;
				default:
				begin
					sfr_we_q <= 1'b1;
					sfr_waddr_q <= wa;
					sfr_wdata_q <= wd;
				end
				endcase
		end
		S_CODE_READ_MOVE:
		begin
			a_q <= code_rdata;
			code_addr_q <= pc_q;
			state_q <= S_FETCH;
		end
		default: state_q <= S_FETCH;
		endcase
	end
end

// no reset on the ram: contents are undefined after power-up
always @(posedge clk_sys)
begin
	if (!rst && (state_q == S_EXEC || state_q == S_CALL) && we && !wsfr)
		ram[wa] <= wd;
end

endmodule

// ==== common/cpu_core_defs.vh ====
`ifndef CPU_CORE_DEFS_VH
`define CPU_CORE_DEFS_VH
// ==========
// core special function register addresses
`define SFR_ACC 8'hE0
`define SFR_B 8'hF0
`define SFR_PSW 8'hD0
`define SFR_SP 8'h81
`define SFR_DPL 8'h82
`define SFR_DPH 8'h83
// ==========
// reset values, status word fields and bit-addressable RAM base
`define SP_RST 8'h07
`define PC_RST 16'h0000
`define PSW_CY 7
`define PSW_AC 6
`define PSW_OV 2
`define BIT_RAM_BASE 4'h2
`endif

// ==== verif/cpu_instruction_set_decoder_assertions.sv ====
`timescale 1ns/1ps
`include "cpu_core_defs.vh"
module decoder_port_checker (
	input wire clk_sys,
	input wire rst,
	input wire [15:0] code_addr_q,
	input wire [7:0] code_rdata,
	input wire [15:0] extended_internal_data_ram_addr,
	input wire [7:0] extended_internal_data_ram_wdata,
	input wire [7:0] extended_internal_data_ram_rdata,
	input wire extended_internal_data_ram_we,
	input wire [7:0] sfr_raddr,
	input wire [7:0] sfr_rdata,
	input wire sfr_we_q,
	input wire [7:0] sfr_waddr_q,
	input wire [7:0] sfr_wdata_q
);
	// ==========
	// port behaviour
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_sfr_we_pulse: assert property (sfr_we_q |=> !sfr_we_q) else $error("sfr write too long");
	a_core_sfr_hidden: assert property (sfr_we_q |->
		!(sfr_waddr_q inside {`SFR_ACC, `SFR_B, `SFR_PSW, `SFR_SP, `SFR_DPL, `SFR_DPH}))
		else $error("core register on sfr port");
	a_low_ram_hidden: assert property (sfr_we_q |-> sfr_waddr_q[7]) else $error("ram byte on sfr port");
	a_extended_internal_data_ram_we_pulse: assert property (extended_internal_data_ram_we |=> !extended_internal_data_ram_we) else $error("extended_internal_data_ram write too long");
	a_extended_internal_data_ram_we_cause: assert property (extended_internal_data_ram_we |-> $past(code_rdata) == 8'hF0) else $error("stray extended_internal_data_ram write");
	a_reset_pc_zero: assert property ($fell(rst) |-> code_addr_q == `PC_RST) else $error("pc not cleared");
	a_first_fetch_step: assert property ($fell(rst) |=> code_addr_q == 16'h0001) else $error("bad first step");
	a_reset_quiet: assert property ($fell(rst) |-> !sfr_we_q && !extended_internal_data_ram_we) else $error("write out of reset");
	cover property (sfr_we_q);
	cover property (extended_internal_data_ram_we);
	cover property (code_addr_q == 16'h0100);
endmodule

// ==== verif/code_data_model.sv ====
`timescale 1ns/1ps
module code_data_model (
	input wire clk_sys,
	input wire [15:0] code_addr,
	output wire [7:0] code_rdata,
	input wire [15:0] extended_internal_data_ram_addr,
	input wire [7:0] extended_internal_data_ram_wdata,
	output wire [7:0] extended_internal_data_ram_rdata,
	input wire extended_internal_data_ram_we,
	input wire [7:0] sfr_raddr,
	output wire [7:0] sfr_rdata
);
	// ==========
	// memories, asynchronous read as the core expects
	logic [7:0] rom [0:65535];
	logic [7:0] extended_internal_data_ram [0:65535];
	assign code_rdata = rom[code_addr];
	assign extended_internal_data_ram_rdata = extended_internal_data_ram[extended_internal_data_ram_addr];
	// address folded in so a wrong read address shows up
	assign sfr_rdata = ~sfr_raddr;
	initial
	begin
		for (int i = 0; i < 65536; i++)
		begin
			rom[i] = 8'h00;
			extended_internal_data_ram[i] = 8'hC3;
		end
	end
	always @(posedge clk_sys)
	begin
		if (extended_internal_data_ram_we)
			extended_internal_data_ram[extended_internal_data_ram_addr] <= extended_internal_data_ram_wdata;
	end
endmodule

// ==== verif/cpu_instruction_set_decoder_tb.sv ====
`timescale 1ns/1ps
module cpu_instruction_set_decoder_tb;
	logic clk_sys;
	logic rst;
	wire [15:0] code_addr_q;
	wire [7:0] code_rdata;
	wire [15:0] extended_internal_data_ram_addr;
	wire [7:0] extended_internal_data_ram_wdata;
	wire [7:0] extended_internal_data_ram_rdata;
	wire extended_internal_data_ram_we;
	wire [7:0] sfr_raddr;
	wire [7:0] sfr_rdata;
	wire sfr_we_q;
	wire [7:0] sfr_waddr_q;
	wire [7:0] sfr_wdata_q;
	logic [7:0] wa;
	logic [7:0] wd;
	int bad_count = 0;
	int checks_done = 0;
	cpu_instruction_set_decoder DUT (.clk_sys(clk_sys), .rst(rst), .code_addr_q(code_addr_q),
		.code_rdata(code_rdata), .extended_internal_data_ram_addr(extended_internal_data_ram_addr), .extended_internal_data_ram_wdata(extended_internal_data_ram_wdata), .extended_internal_data_ram_rdata(extended_internal_data_ram_rdata),
		.extended_internal_data_ram_we(extended_internal_data_ram_we), .sfr_raddr(sfr_raddr), .sfr_rdata(sfr_rdata), .sfr_we_q(sfr_we_q),
		.sfr_waddr_q(sfr_waddr_q), .sfr_wdata_q(sfr_wdata_q));
	code_data_model mdl (.clk_sys(clk_sys), .code_addr(code_addr_q), .code_rdata(code_rdata),
		.extended_internal_data_ram_addr(extended_internal_data_ram_addr), .extended_internal_data_ram_wdata(extended_internal_data_ram_wdata), .extended_internal_data_ram_rdata(extended_internal_data_ram_rdata), .extended_internal_data_ram_we(extended_internal_data_ram_we),
		.sfr_raddr(sfr_raddr), .sfr_rdata(sfr_rdata));
	// ==========
	// helpers
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic load(input logic [15:0] at, input logic [7:0] b [$]);
		foreach (b[i])
			mdl.rom[16'(at + i)] = b[i];
	endtask
	// program is loaded while reset holds, so the old loop cannot run it half-written
	task automatic hold;
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (5) @(posedge clk_sys);
	endtask
	task automatic run;
		int n;
		n = 0;
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		while (sfr_we_q !== 1'b1 && n < 300)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		// a program that never reaches its write is a failure, not a stale pass
		if (n >= 300)
			bad_count++;
		wa = sfr_waddr_q;
		wd = sfr_wdata_q;
	endtask
	task automatic give_verdict;
		$display("checks=%0d bad=%0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_arith;
		hold();
		load(16'h0000, '{8'h74, 8'h12, 8'hA5, 8'hD3, 8'h34, 8'h34, 8'hF5, 8'h90, 8'h80, 8'hFE});
		run();
		check8(wa, 8'h90);
		check8(wd, 8'h47);
		$display("arith done");
	endtask
	task automatic t_rotate;
		hold();
		load(16'h0000, '{8'hD3, 8'h74, 8'h81, 8'h33, 8'hC4, 8'hF5, 8'h90, 8'h80, 8'hFE});
		run();
		check8(wd, 8'h30);
		$display("rotate done");
	endtask
	task automatic t_jumps;
		hold();
		load(16'h0000, '{8'h02, 8'h01, 8'h00});
		load(16'h0100, '{8'h80, 8'h02, 8'h74, 8'hAA, 8'h21, 8'h10});
		load(16'h0110, '{8'h74, 8'h55, 8'hF5, 8'h90, 8'h80, 8'hFE});
		run();
		check8(wd, 8'h55);
		$display("jumps done");
	endtask
	task automatic t_extended_internal_data_ram;
		hold();
		load(16'h0000, '{8'h90, 8'h12, 8'h34, 8'h74, 8'h5A, 8'hF0, 8'hE4, 8'hE0, 8'h04, 8'hF5, 8'h90, 8'h80, 8'hFE});
		run();
		check8(mdl.extended_internal_data_ram[16'h1234], 8'h5A);
		check8(wd, 8'h5B);
		$display("extended_internal_data_ram done");
	endtask
	task automatic t_loops;
		hold();
		load(16'h0000, '{8'h78, 8'h03, 8'hE4, 8'h04, 8'hD8, 8'hFD, 8'hF5, 8'h90, 8'h80, 8'hFE});
		run();
		check8(wd, 8'h03);
		hold();
		load(16'h0000, '{8'h74, 8'h07, 8'hB4, 8'h07, 8'h02, 8'h74, 8'h11, 8'hB4, 8'h12, 8'h02,
			8'h74, 8'hEE, 8'hF5, 8'h90, 8'h80, 8'hFE});
		run();
		check8(wd, 8'h11);
		$display("loops done");
	endtask
	task automatic t_data;
		hold();
		load(16'h0000, '{8'h74, 8'h0C, 8'h75, 8'hF0, 8'h05, 8'hA4, 8'h75, 8'hF0, 8'h07, 8'h84, 8'h79, 8'h30,
			8'hF7, 8'h43, 8'h30, 8'hF0, 8'hC0, 8'h30, 8'hD0, 8'h31, 8'hE4, 8'h09, 8'hE7, 8'hF5, 8'h90,
			8'h80, 8'hFE});
		run();
		check8(wd, 8'hF8);
		$display("data done");
	endtask
	task automatic t_bits;
		hold();
		load(16'h0000, '{8'hE5, 8'hA0, 8'hF5, 8'h20, 8'h10, 8'h04, 8'h02, 8'h74, 8'hEE, 8'hA2, 8'h04, 8'hA0, 8'h05,
			8'h92, 8'h07, 8'h90, 8'h00, 8'h18, 8'h74, 8'h05, 8'h73, 8'h80, 8'hFE, 8'h00, 8'h3C, 8'h00, 8'h00, 8'h00,
			8'h00, 8'hE4, 8'h93, 8'h62, 8'h20, 8'hE5, 8'h20, 8'hF5, 8'h90, 8'h80, 8'hFE});
		run();
		check8(wa, 8'h90);
		check8(wd, 8'hF3);
		$display("bits done");
	endtask
	initial
	begin
		rst = 1'b1;
		t_arith();
		t_rotate();
		t_jumps();
		t_extended_internal_data_ram();
		t_loops();
		t_data();
		t_bits();
		give_verdict();
	end
	initial
	begin
		#(5000 * 100);
		bad_count++;
		give_verdict();
	end
endmodule
bind cpu_instruction_set_decoder decoder_port_checker chk (.clk_sys(clk_sys), .rst(rst),
	.code_addr_q(code_addr_q), .code_rdata(code_rdata), .extended_internal_data_ram_addr(extended_internal_data_ram_addr), .extended_internal_data_ram_wdata(extended_internal_data_ram_wdata),
	.extended_internal_data_ram_rdata(extended_internal_data_ram_rdata), .extended_internal_data_ram_we(extended_internal_data_ram_we), .sfr_raddr(sfr_raddr), .sfr_rdata(sfr_rdata),
	.sfr_we_q(sfr_we_q), .sfr_waddr_q(sfr_waddr_q), .sfr_wdata_q(sfr_wdata_q));
